// *** verilog/osw_pkg.sv ***
package osw_pkg;
  // Register indices
  localparam logic [2:0]  REG_OSC_HI     = 3'h0;
  localparam logic [2:0]  REG_OSC_LO     = 3'h1;
  localparam logic [2:0]  REG_TRIM       = 3'h2;
  localparam logic [2:0]  REG_AUX        = 3'h3;
  localparam logic [2:0]  REG_REFO       = 3'h4;
  localparam logic [2:0]  REG_UNLOCK     = 3'h5;
  localparam logic [15:0] UNLOCK_KEY1    = 16'h5a3c;
  localparam logic [15:0] UNLOCK_KEY2    = 16'hc3a5;
  // Reset values
  localparam logic [15:0] AUX_RST        = 16'h2700;
  localparam logic [15:0] REFO_RST       = 16'h0000;
  localparam logic [5:0]  TRIM_RST       = 6'h00;
  // Oscillator control fields
  localparam int          OSC_CURRENT_OSC_SEL_LSB   = 12;
  localparam int          OSC_NEXT_OSC_SEL_LSB   = 8;
  localparam int          OSC_CLKLOCK    = 7;
  localparam int          OSC_IOLOCK     = 6;
  localparam int          OSC_LOCK       = 5;
  localparam int          OSC_CF         = 3;
  localparam int          OSC_SWREQ      = 0;
  // Auxiliary control fields
  localparam int          AUX_EN         = 15;
  localparam int          AUX_LOCKED     = 14;
  localparam int          AUX_SEL        = 13;
  localparam int          AUX_DIV_LSB    = 8;
  localparam int          AUX_ASRC       = 7;
  localparam int          AUX_FRC        = 6;
  // Reference output fields
  localparam int          REFO_ON        = 15;
  localparam int          REFO_SLP       = 13;
  localparam int          REFO_SEL       = 12;
  localparam int          REFO_DIV_LSB   = 8;
  // Oscillator select codes
  localparam logic [2:0]  OSC_FRC        = 3'h0;
  localparam logic [2:0]  OSC_FRC_PLL    = 3'h1;
  localparam logic [2:0]  OSC_PRI        = 3'h2;
  localparam logic [2:0]  OSC_PRI_PLL    = 3'h3;
  localparam logic [2:0]  OSC_RSVD       = 3'h4;
  localparam logic [2:0]  OSC_LOW_POWER_RC_OSC       = 3'h5;
  localparam logic [2:0]  OSC_FRC_DIV16  = 3'h6;
  localparam logic [2:0]  OSC_FRC_POST   = 3'h7;
  localparam logic [3:0]  NEW_CLK_WAIT   = 4'ha;

  typedef enum logic [1:0] {SW_IDLE, SW_START, SW_COUNT, SW_SWITCH} osw_sw_state_t;
  typedef enum logic [1:0] {AUX_REF_NONE, AUX_REF_PRIMARY, AUX_REF_FASTRC} osw_aux_ref_t;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } osw_bus_req_t;

  typedef struct packed {
    logic fast_rc;
    logic primary;
    logic low_power_rc;
    logic pll;
  } osw_osc_run_t;
endpackage

// *** verilog/osw_clock_ctrl.sv ***
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module osw_clock_ctrl (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  por_rst,
  input  wire osw_pkg::osw_bus_req_t bus_req,
  output logic [15:0]                rd_data,
  input  wire logic                  clock_switch_config_bit,
  input  wire logic                  clock_fail_monitor_cfg,
  input  wire logic [2:0]            initial_osc_config,
  input  wire logic                  wdt_enable,
  input  wire logic                  sleep_mode,
  input  wire logic                  osc_startup_done,
  input  wire logic                  pll_lock_in,
  input  wire logic                  new_clk_tick,
  input  wire logic                  clock_fail_event,
  input  wire logic                  aux_pll_lock_in,
  input  wire logic                  aux_osc_tick,
  input  wire logic                  pll_vco_tick,
  input  wire logic                  xtal_tick,
  output logic signed [5:0]          fast_rc_trim_field,
  output logic                       aux_pll_run,
  output osw_pkg::osw_aux_ref_t      aux_pll_ref,
  output logic                       aux_div_from_aux_osc,
  output logic                       aux_clk_tick,
  output logic                       refout_pin,
  output logic                       refout_active,
  output logic [2:0]                 sys_clk_sel,
  output logic                       switch_busy,
  output osw_pkg::osw_osc_run_t      osc_run
);
  import osw_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic osw_osc_run_t src_run(input logic [2:0] code);
    osw_osc_run_t r;
    r.fast_rc      = (code == OSC_FRC) || (code == OSC_FRC_PLL) ||
                     (code == OSC_FRC_DIV16) || (code == OSC_FRC_POST);
    r.primary      = (code == OSC_PRI) || (code == OSC_PRI_PLL);
    r.low_power_rc = (code == OSC_LOW_POWER_RC_OSC);
    r.pll          = (code == OSC_FRC_PLL) || (code == OSC_PRI_PLL);
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  osw_sw_state_t state_q;
  logic [2:0]    current_osc_sel_q;
  logic [2:0]    next_osc_sel_q;
  logic [2:0]    target_q;
  logic          swreq_q;
  logic          clklock_q;
  logic          iolock_q;
  logic          lock_q;
  logic          cf_q;
  logic          cfg_load_q;
  logic [3:0]    wait_cnt_q;
  logic          key1_q;
  logic          unlocked_q;
  logic [5:0]    trim_q;
  logic [15:0]   aux_q;
  logic          aux_locked_q;
  logic [15:0]   refo_q;
  logic [7:0]    aux_cnt_q;
  logic          aux_tick_q;
  logic [14:0]   ref_cnt_q;
  logic          ref_pin_q;
  logic          ref_act_q;
  osw_osc_run_t  osc_run_q;
  logic [15:0]   rd_data_q;

  logic          sw_en;
  logic          any_rst;
  logic          wr_osc_hi;
  logic          wr_osc_lo;
  logic          sw_start;
  logic          sw_redundant;
  logic          sw_done;
  logic          src_ready;
  osw_osc_run_t  tgt_run;
  osw_osc_run_t  cur_run;
  logic          clock_fail_monitor_en;
  logic          ref_src_tick;
  logic          ref_enable;
  logic          aux_src_tick;
  logic [7:0]    aux_lim;
  logic [14:0]   ref_lim;

  assign any_rst      = rst || por_rst;
  assign sw_en        = !clock_switch_config_bit;
  assign clock_fail_monitor_en      = sw_en && clock_fail_monitor_cfg;
  assign wr_osc_hi    = bus_req.wr && unlocked_q && (bus_req.addr == REG_OSC_HI);
  assign wr_osc_lo    = bus_req.wr && unlocked_q && (bus_req.addr == REG_OSC_LO);
  assign tgt_run      = src_run(target_q);
  assign cur_run      = src_run(current_osc_sel_q);
  assign sw_start     = (state_q == SW_IDLE) && swreq_q && sw_en && (current_osc_sel_q != next_osc_sel_q);
  assign sw_redundant = (state_q == SW_IDLE) && swreq_q && (current_osc_sel_q == next_osc_sel_q);
  assign sw_done      = (state_q == SW_SWITCH);
  assign src_ready    = (!tgt_run.primary || osc_startup_done) &&
                        (!tgt_run.pll || pll_lock_in);

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      key1_q     <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (bus_req.wr) begin
      // Only the very next write after the key pair is let through
      key1_q     <= (bus_req.addr == REG_UNLOCK) && (bus_req.wdata == UNLOCK_KEY1);
      unlocked_q <= (bus_req.addr == REG_UNLOCK) && (bus_req.wdata == UNLOCK_KEY2)
                    && key1_q;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator control register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      current_osc_sel_q     <= OSC_FRC;
      next_osc_sel_q     <= OSC_FRC;
      cfg_load_q <= 1'b1;
      clklock_q  <= 1'b0;
      iolock_q   <= 1'b0;
    end else begin
      cfg_load_q <= 1'b0;
      if (cfg_load_q || !sw_en) begin
        current_osc_sel_q <= initial_osc_config;
      end else if (sw_done) begin
        current_osc_sel_q <= target_q;
      end
      if (cfg_load_q) begin
        next_osc_sel_q <= initial_osc_config;
      end else if (wr_osc_hi) begin
        next_osc_sel_q <= bus_req.wdata[OSC_NEXT_OSC_SEL_LSB +: 3];
      end
      if (wr_osc_lo) begin
        clklock_q <= bus_req.wdata[OSC_CLKLOCK];
        iolock_q  <= bus_req.wdata[OSC_IOLOCK];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (por_rst || !sw_en) begin
      swreq_q <= 1'b0;
    end else if (sw_redundant || sw_done) begin
      swreq_q <= 1'b0;
    end else if (wr_osc_lo && bus_req.wdata[OSC_SWREQ]) begin
      swreq_q <= 1'b1;
    end
  end

  // Clock fail flag: a new failure wins over any clear
  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      cf_q <= 1'b0;
    end else if (clock_fail_event && clock_fail_monitor_en) begin
      cf_q <= 1'b1;
    end else if (sw_start) begin
      cf_q <= 1'b0;
    end else if (wr_osc_lo && !bus_req.wdata[OSC_CF]) begin
      cf_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (por_rst || sw_start) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= pll_lock_in && (cur_run.pll || (state_q != SW_IDLE && tgt_run.pll));
    end
  end

  // ---------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      state_q    <= SW_IDLE;
      target_q   <= OSC_FRC;
      wait_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        SW_IDLE: begin
          if (sw_start) begin
            target_q <= next_osc_sel_q;
            state_q  <= SW_START;
          end
        end
        SW_START: begin
          wait_cnt_q <= 4'h0;
          if (src_ready) begin
            state_q <= SW_COUNT;
          end
        end
        SW_COUNT: begin
          if (new_clk_tick) begin
            wait_cnt_q <= wait_cnt_q + 4'h1;
            if (wait_cnt_q == NEW_CLK_WAIT - 4'h1) begin
              state_q <= SW_SWITCH;
            end
          end
        end
        SW_SWITCH: begin
          state_q <= SW_IDLE;
        end
      endcase
    end
  end

  // Oscillators kept running; old one dropped once current moves on, except low-power RC while wdt_enable or fail monitor is on
  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      osc_run_q <= '0;
    end else begin
      osc_run_q.fast_rc      <= cur_run.fast_rc || (switch_busy && tgt_run.fast_rc);
      osc_run_q.primary      <= cur_run.primary || (switch_busy && tgt_run.primary);
      osc_run_q.pll          <= cur_run.pll || (switch_busy && tgt_run.pll);
      osc_run_q.low_power_rc <= cur_run.low_power_rc || (switch_busy && tgt_run.low_power_rc)
                                || wdt_enable || clock_fail_monitor_en;
    end
  end

  // ---------------------------------------------------------------
  // Trim and auxiliary clock registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      trim_q <= TRIM_RST;
      aux_q  <= AUX_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == REG_TRIM) begin
        trim_q <= bus_req.wdata[5:0];
      end
      if (bus_req.addr == REG_AUX) begin
        aux_q <= bus_req.wdata & 16'he7c0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      aux_locked_q <= 1'b0;
    end else begin
      aux_locked_q <= aux_q[AUX_EN] && aux_pll_lock_in;
    end
  end

  assign aux_src_tick = aux_q[AUX_SEL] ? aux_osc_tick : pll_vco_tick;
  assign aux_lim      = (aux_q[AUX_DIV_LSB +: 3] == 3'h0) ? 8'hff :
                        8'((9'h001 << (3'h7 - aux_q[AUX_DIV_LSB +: 3])) - 9'h001);

  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      aux_cnt_q  <= 8'h00;
      aux_tick_q <= 1'b0;
    end else if (aux_src_tick) begin
      aux_tick_q <= (aux_cnt_q >= aux_lim);
      aux_cnt_q  <= (aux_cnt_q >= aux_lim) ? 8'h00 : aux_cnt_q + 8'h01;
    end else begin
      aux_tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Reference clock output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      refo_q <= REFO_RST;
    end else if (bus_req.wr && bus_req.addr == REG_REFO) begin
      // Divider taken as written; software disables output first
      refo_q <= bus_req.wdata & 16'hbf00;
    end
  end

  assign ref_enable   = refo_q[REFO_ON] && (!sleep_mode || refo_q[REFO_SLP]);
  assign ref_src_tick = refo_q[REFO_SEL] ? xtal_tick : 1'b1;
  assign ref_lim      = 15'((16'h0001 << refo_q[REFO_DIV_LSB +: 4]) - 16'h0001);

  always_ff @(posedge sys_clk) begin
    if (any_rst || !ref_enable) begin
      ref_cnt_q <= 15'h0000;
      ref_pin_q <= 1'b0;
    end else if (ref_src_tick) begin
      ref_pin_q <= (ref_cnt_q >= ref_lim);
      ref_cnt_q <= (ref_cnt_q >= ref_lim) ? 15'h0000 : ref_cnt_q + 15'h0001;
    end else begin
      ref_pin_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      ref_act_q <= 1'b0;
    end else begin
      ref_act_q <= ref_enable;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (any_rst || !bus_req.rd) begin
      rd_data_q <= 16'h0000;
    end else begin
      unique case (bus_req.addr)
        REG_OSC_HI, REG_OSC_LO: rd_data_q <= {1'b0, current_osc_sel_q, 1'b0, next_osc_sel_q, clklock_q,
                                              iolock_q, lock_q, 1'b0, cf_q, 2'b00, swreq_q};
        REG_TRIM: rd_data_q <= {10'h000, trim_q};
        REG_AUX:  rd_data_q <= {aux_q[15], aux_locked_q, aux_q[13:0]};
        REG_REFO: rd_data_q <= refo_q;
        default:  rd_data_q <= 16'h0000;
      endcase
    end
  end

  assign rd_data              = rd_data_q;
  assign fast_rc_trim_field   = $signed(trim_q);
  assign aux_pll_run          = aux_q[AUX_EN];
  assign aux_pll_ref          = aux_q[AUX_FRC]  ? AUX_REF_FASTRC :
                                aux_q[AUX_ASRC] ? AUX_REF_PRIMARY : AUX_REF_NONE;
  assign aux_div_from_aux_osc = aux_q[AUX_SEL];
  assign aux_clk_tick         = aux_tick_q;
  assign refout_pin           = ref_pin_q;
  assign refout_active        = ref_act_q;
  assign sys_clk_sel          = current_osc_sel_q;
  assign switch_busy          = (state_q != SW_IDLE);
  assign osc_run              = osc_run_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_swreq_disabled;
    @(posedge sys_clk) disable iff (any_rst)
    clock_switch_config_bit |=> !swreq_q;
  endproperty
  a_swreq_disabled: assert property (p_swreq_disabled) else $error("request set while disabled");

  property p_current_osc_sel_initial;
    @(posedge sys_clk) disable iff (any_rst)
    clock_switch_config_bit && $stable(initial_osc_config) |=> current_osc_sel_q == $past(initial_osc_config);
  endproperty
  a_current_osc_sel_initial: assert property (p_current_osc_sel_initial) else $error("current select not initial config");

  property p_redundant;
    @(posedge sys_clk) disable iff (any_rst)
    sw_redundant |=> !swreq_q && state_q == SW_IDLE;
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch not aborted");

  property p_start_clears;
    @(posedge sys_clk) disable iff (any_rst)
    sw_start && !clock_fail_event |=> !cf_q && !lock_q;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("flags not cleared at start");

  property p_wait_ready;
    @(posedge sys_clk) disable iff (any_rst)
    state_q == SW_START && !src_ready |=> state_q == SW_START;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("left start before source ready");

  property p_ten_ticks;
    @(posedge sys_clk) disable iff (any_rst)
    $rose(state_q == SW_SWITCH) |-> wait_cnt_q == NEW_CLK_WAIT && $past(new_clk_tick);
  endproperty
  a_ten_ticks: assert property (p_ten_ticks) else $error("changeover without ten new clocks");

  property p_done;
    @(posedge sys_clk) disable iff (any_rst)
    sw_done && sw_en |=> current_osc_sel_q == $past(target_q) && !swreq_q;
  endproperty
  a_done: assert property (p_done) else $error("switch completion wrong");

  property p_current_osc_sel_hold;
    @(posedge sys_clk) disable iff (any_rst)
    sw_en && !cfg_load_q && state_q != SW_SWITCH && $past(sw_en) |=> $stable(current_osc_sel_q);
  endproperty
  a_current_osc_sel_hold: assert property (p_current_osc_sel_hold) else $error("clock changed before final step");

  property p_low_power_rc_osc_kept;
    @(posedge sys_clk) disable iff (any_rst)
    wdt_enable |=> osc_run_q.low_power_rc;
  endproperty
  a_low_power_rc_osc_kept: assert property (p_low_power_rc_osc_kept) else $error("low-power RC stopped");

  property p_ref_off;
    @(posedge sys_clk) disable iff (any_rst)
    !ref_enable |=> !ref_pin_q;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference output while disabled");

  property p_locked_needs_en;
    @(posedge sys_clk) disable iff (any_rst)
    !aux_q[AUX_EN] |=> !aux_locked_q;
  endproperty
  a_locked_needs_en: assert property (p_locked_needs_en) else $error("aux locked while off");

  property p_unlock_gate;
    @(posedge sys_clk) disable iff (any_rst)
    bus_req.wr && bus_req.addr == REG_OSC_HI && !unlocked_q |=> $stable(next_osc_sel_q);
  endproperty
  a_unlock_gate: assert property (p_unlock_gate) else $error("locked write changed next select");
endmodule

// *** sim/osw_src_model.sv ***
`timescale 1ns/1ps
module osw_src_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic xtal_on,
  output logic      startup_done,
  output logic      new_tick
);
  logic [4:0] ost_q;
  logic [1:0] div_q;
  // Crystal start-up timer, expires 31 cycles after start
  always_ff @(posedge sys_clk) begin
    if (rst || !xtal_on) ost_q <= 5'h00;
    else if (ost_q != 5'h1f) ost_q <= ost_q + 5'h01;
  end
  assign startup_done = (ost_q == 5'h1f);
  // New source clock, one tick every four cycles
  always_ff @(posedge sys_clk) begin
    div_q <= rst ? 2'h0 : div_q + 2'h1;
  end
  assign new_tick = (div_q == 2'h3);
endmodule

// *** sim/osw_clock_ctrl_tb.sv ***
`timescale 1ns/1ps
module osw_clock_ctrl_tb;
  import osw_pkg::*;
  logic              sys_clk, rst, por_rst, sw_cfg, slp, osc_startup_timer, tick, a_lk, a_tk, v_tk, x_tk;
  logic              lo, a_run, a_sel, a_ck, r_pin, r_act, busy, b, mon, cfe, tk_all;
  logic [15:0]       rd_data, v, w, av;
  logic [2:0]        init_cfg, sel;
  logic signed [5:0] trim;
  osw_bus_req_t      bus;
  osw_aux_ref_t      a_ref;
  osw_osc_run_t      run;
  int                n_fail, check_count, cnt;

  osw_clock_ctrl uut (.sys_clk(sys_clk), .rst(rst), .por_rst(por_rst), .bus_req(bus),
    .rd_data(rd_data), .clock_switch_config_bit(sw_cfg), .clock_fail_monitor_cfg(mon),
    .initial_osc_config(init_cfg), .wdt_enable(mon), .sleep_mode(slp),
    .osc_startup_done(osc_startup_timer), .pll_lock_in(lo), .new_clk_tick(tick), .clock_fail_event(cfe),
    .aux_pll_lock_in(a_lk), .aux_osc_tick(a_tk), .pll_vco_tick(v_tk), .xtal_tick(x_tk),
    .fast_rc_trim_field(trim), .aux_pll_run(a_run), .aux_pll_ref(a_ref),
    .aux_div_from_aux_osc(a_sel), .aux_clk_tick(a_ck), .refout_pin(r_pin),
    .refout_active(r_act), .sys_clk_sel(sel), .switch_busy(busy), .osc_run(run));
  osw_src_model src (.sys_clk(sys_clk), .rst(por_rst), .xtal_on(run.primary),
    .startup_done(osc_startup_timer), .new_tick(tick));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) {a_tk, v_tk, x_tk} <= tk_all ? 3'h4 : 3'($urandom);

  function automatic osw_aux_ref_t ref_exp(input logic [15:0] d);
    return d[AUX_FRC] ? AUX_REF_FASTRC : (d[AUX_ASRC] ? AUX_REF_PRIMARY : AUX_REF_NONE);
  endfunction
  function automatic int aux_div(input logic [2:0] c);
    return (c == 3'h0) ? 256 : (1 << (7 - c));
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 v = rd_data;
    @(posedge sys_clk);
  endtask
  task automatic uwr(input logic [2:0] a, input logic [15:0] d);
    wr(REG_UNLOCK, UNLOCK_KEY1);
    wr(REG_UNLOCK, UNLOCK_KEY2);
    wr(a, d);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_idle;
    for (cnt = 0; cnt < 400; cnt++) begin
      @(posedge sys_clk);
      #1;
      if (busy === 1'b0) break;
    end
    if (cnt == 400) begin
      n_fail++;
      wrap_up();
    end
  endtask

  initial begin
    n_fail = 0; check_count = 0; bus = '0; rst = 1'b1; por_rst = 1'b1; sw_cfg = 1'b0;
    lo = 1'b0; slp = 1'b0; a_lk = 1'b0; init_cfg = OSC_FRC; mon = 1'b0; cfe = 1'b0; tk_all = 1'b0;
    void'($urandom(32'h216b_d752));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(REG_TRIM); chk("trim", v, 16'h0000);
    rd(REG_AUX); chk("aux", v, AUX_RST);
    rd(3'h6); chk("unmapped", v, 16'h0000);
    w = 16'($urandom);
    wr(REG_TRIM, w);
    a_lk <= 1'b1;
    for (int k = 3; k >= 0; k--) begin
      v = (16'($urandom) & 16'ha700) | {8'h00, 2'(k), 6'h00} | (k == 0 ? 16'h8000 : 16'h0000);
      wr(REG_AUX, v);
      av = v;
      chk("aux_ref", 16'(a_ref), 16'(ref_exp(v)));
      chk("aux_run", 16'(a_run), 16'(v[AUX_EN]));
      chk("aux_sel", 16'(a_sel), 16'(v[AUX_SEL]));
    end
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(REG_TRIM); chk("trim_kept", v, {10'h000, w[5:0]});
    chk("trim_out", 16'(trim), 16'(signed'(w[5:0])));
    rd(REG_AUX); chk("lock_bit", 16'(v[AUX_LOCKED]), 16'h0001);
    chk("aux_kept", v, av | 16'h4000);
    $display("Test registers done");
    wr(REG_OSC_HI, {5'h00, OSC_PRI, 8'h00});
    rd(REG_OSC_HI); chk("next_osc_sel_locked", 16'(v[10:8]), 16'(OSC_FRC));
    uwr(REG_OSC_HI, {5'h00, OSC_PRI, 8'h00});
    uwr(REG_OSC_LO, 16'h0001);
    #1 chk("sel_old", 16'(sel), 16'(OSC_FRC));
    chk("busy", 16'(busy), 16'h0001);
    wait_idle();
    chk("current_osc_sel", 16'(sel), 16'(OSC_PRI));
    rd(REG_OSC_LO); chk("osc_word", v & 16'h7701, 16'h2200);
    chk("new_on", 16'(run.primary), 16'h0001);
    chk("old_off", 16'(run.fast_rc), 16'h0000);
    uwr(REG_OSC_LO, 16'h0001);
    repeat (2) @(posedge sys_clk);
    rd(REG_OSC_LO); chk("redundant", v & 16'h7001, 16'h2000);
    mon <= 1'b1;
    cfe <= 1'b1;
    @(posedge sys_clk);
    cfe <= 1'b0;
    rd(REG_OSC_LO); chk("cf_set", 16'(v[OSC_CF]), 16'h0001);
    chk("low_power_rc_osc_on", 16'(run.low_power_rc), 16'h0001);
    uwr(REG_OSC_HI, {5'h00, OSC_FRC, 8'h00});
    uwr(REG_OSC_LO, 16'h0009);
    rd(REG_OSC_LO); chk("cf_clr", 16'(v[OSC_CF]), 16'h0000);
    wait_idle();
    rd(REG_OSC_LO); chk("osc_back", v & 16'h7701, 16'h0000);
    chk("pri_off", 16'(run.primary), 16'h0000);
    $display("Test switching done");
    wr(REG_REFO, 16'h8000);
    repeat (2) @(posedge sys_clk);
    chk("ref_on", {15'h0000, r_act}, 16'h0001);
    slp <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("ref_sleep", {15'h0000, r_act}, 16'h0000);
    wr(REG_REFO, 16'ha000);
    repeat (2) @(posedge sys_clk);
    chk("ref_slp_run", {15'h0000, r_act}, 16'h0001);
    slp <= 1'b0;
    for (int d = 1; d < 4; d++) begin
      wr(REG_REFO, 16'h0000);
      wr(REG_REFO, 16'h8000 | 16'(d << 8));
      cnt = 0;
      repeat (32) begin
        @(posedge sys_clk);
        #1 cnt += int'(r_pin);
      end
      chk("ref_div", 16'(cnt), 16'(32 >> d));
    end
    wr(REG_REFO, 16'h0000);
    wr(REG_REFO, 16'h9000);
    @(posedge sys_clk);
    #1 b = x_tk;
    repeat (16) begin
      @(posedge sys_clk);
      #1 chk("ref_xtal", {15'h0000, r_pin}, {15'h0000, b});
      b = x_tk;
    end
    wr(REG_REFO, 16'h0000);
    repeat (2) @(posedge sys_clk);
    chk("ref_off", {15'h0000, r_pin}, 16'h0000);
    $display("Test reference done");
    tk_all <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      w = {2'b00, 1'(c < 4), 2'b00, 3'(c * 5), 8'h00};
      wr(REG_AUX, w);
      repeat (2) @(posedge sys_clk);
      cnt = 0;
      repeat (256) begin
        @(posedge sys_clk);
        #1 cnt += int'(a_ck);
      end
      chk("aux_div", 16'(cnt), (c < 4) ? 16'(256 / aux_div(3'(c * 5))) : 16'h0000);
    end
    $display("Test divider done");
    sw_cfg <= 1'b1;
    init_cfg <= OSC_LOW_POWER_RC_OSC;
    repeat (3) @(posedge sys_clk);
    chk("cfg_sel", 16'(sel), 16'(OSC_LOW_POWER_RC_OSC));
    uwr(REG_OSC_LO, 16'h0001);
    rd(REG_OSC_LO); chk("req_held", 16'(v[0]), 16'h0000);
    $display("Test disabled done");
    wrap_up();
  end
endmodule
